// [rtl/epp_pkg.sv]
// package for the eeprom programming port: widths, pin levels, reset values
// assumes a single 25 MHz system clock domain
package epp_pkg;
   localparam int          EPP_DATA_W      = 8;     // multiplexed bus width
   localparam int          EPP_NUM_REGS    = 16;    // programming registers decoded
   localparam int          EPP_ADDR_W      = 4;     // address bits used to index the registers
   localparam logic [3:0]  EPP_MODE_PATTERN = 4'hA; // sel3..sel0 = 1,0,1,0
   localparam logic [7:0]  EPP_REG_RESET   = 8'h00; // register reset value
   localparam logic [7:0]  EPP_ADDR_RESET  = 8'h00; // latched address reset value
   localparam int          EPP_SYNC_STAGES = 2;     // pin synchroniser depth

   // access phase of the port
   typedef enum logic [2:0] {
      EPP_IDLE  = 3'b001,
      EPP_READ  = 3'b010,
      EPP_WRITE = 3'b100
   } epp_state_t;
endpackage

// [rtl/epp_port.sv]
// eeprom programming port: parallel multiplexed-bus register access
// assumes strobes come from an external programmer, asynchronous to clk_sys
// Summary of operation
// (RULE_01) reset input clears port and registers
// (RULE_02) one 8-bit bus for all data
// (RULE_03) address captured on latch strobe fall
// (RULE_04) programmer starts access with latch pulse
// (RULE_05) select and read low drive bus
// (RULE_06) select and write low store byte
// (RULE_07) strobes ignored while select is high; code gates read and write only, the latch strobe still captures an address
// (RULE_08) programmer deselects between accesses
// (RULE_09) programmer keeps oscillator running
// (RULE_10) mode pins low-high-low-high enter programming
// (RULE_11) programmer never asserts read and write together
`timescale 1ns/100ps
module epp_port
   import epp_pkg::*;
#(
   parameter int N_REGS = EPP_NUM_REGS
) (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire logic                  prog_iface_reset,
   input  wire logic                  prog_mode_sel_0,
   input  wire logic                  prog_mode_sel_1,
   input  wire logic                  prog_mode_sel_2,
   input  wire logic                  prog_mode_sel_3,
   input  wire logic                  prog_addr_latch_strobe,
   input  wire logic                  prog_select_n,
   input  wire logic                  prog_read_strobe_n,
   input  wire logic                  prog_write_strobe_n,
   input  wire logic [EPP_DATA_W-1:0] prog_addr_data_bus_i,
   output logic      [EPP_DATA_W-1:0] prog_addr_data_bus_o,
   output logic                       prog_addr_data_bus_oe,
   output logic                       prog_mode_active,
   output logic      [EPP_DATA_W-1:0] prog_addr_out,
   output logic                       prog_wr_pulse,
   output logic                       prog_rd_pulse,
   input  wire logic [EPP_DATA_W-1:0] array_rd_data
);
   localparam int NS = 8 + EPP_DATA_W;   // synchronised pin count

   logic [NS-1:0]            pins_raw;      // asynchronous pin group
   logic [NS-1:0]            pins_s;        // synchronised pin group
   logic                     ale_s;         // latch strobe, synced
   logic                     cs_n_s;        // select, synced
   logic                     rd_n_s;        // read strobe, synced
   logic                     wr_n_s;        // write strobe, synced
   logic                     prog_iface_reset_s;        // interface reset, synced
   logic [3:0]               mode_s;        // mode pins sel3..sel0
   logic [EPP_DATA_W-1:0]    bus_s;         // bus input, synced
   logic                     ale_d_r;       // previous latch strobe
   logic                     iface_rst;     // combined local reset
   logic [EPP_DATA_W-1:0]    addr_r;        // latched register address
   logic [EPP_DATA_W-1:0]    regs_r [N_REGS]; // programming registers
   epp_state_t               state_r;       // access phase
   epp_state_t               state_nxt;     // next access phase
   logic [EPP_DATA_W-1:0]    rd_data_r;     // bus output data
   logic                     rd_req;        // read qualified by select
   logic                     wr_req;        // write qualified by select

   // register space or memory array: top bit clear and the whole index below N_REGS,
   // so an index past the register file reaches the array instead of aliasing
   function automatic logic addr_hits_reg(input logic [EPP_DATA_W-1:0] a);
      return (a[EPP_DATA_W-1] == 1'b0) && (int'(a[EPP_DATA_W-2:0]) < N_REGS);
   endfunction

   assign pins_raw = {prog_addr_latch_strobe, prog_select_n, prog_read_strobe_n,
                      prog_write_strobe_n, prog_iface_reset, prog_mode_sel_3,
                      prog_mode_sel_2, prog_mode_sel_1, prog_addr_data_bus_i};

   // every pin is asynchronous, so all pass two flip-flops
   epp_sync #(.WIDTH(NS), .RST_VAL(1'b0)) u_sync (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .pin_in   (pins_raw),
      .pin_sync (pins_s)
   );

   // sel_0 folded separately to keep the concat readable
   logic [1:0] sel0_q;   // sel_0 two-stage synchroniser
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sel0_q <= 2'h0;
      end else begin
         sel0_q <= {sel0_q[0], prog_mode_sel_0};
      end
   end

   assign ale_s  = pins_s[NS-1];
   assign cs_n_s = pins_s[NS-2];
   assign rd_n_s = pins_s[NS-3];
   assign wr_n_s = pins_s[NS-4];
   assign prog_iface_reset_s = pins_s[NS-5];
   assign mode_s = {pins_s[NS-6], pins_s[NS-7], pins_s[NS-8], sel0_q[1]};
   assign bus_s  = pins_s[EPP_DATA_W-1:0];

   // (RULE_10) mode pattern check
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         prog_mode_active <= 1'b0;
      end else begin
         prog_mode_active <= (mode_s == EPP_MODE_PATTERN);
      end
   end

   // (RULE_01) interface reset source
   assign iface_rst = prog_iface_reset_s || !prog_mode_active;

   // (RULE_07) select gates both strobes
   assign rd_req = !cs_n_s && !rd_n_s && wr_n_s;
   assign wr_req = !cs_n_s && !wr_n_s && rd_n_s;

   // previous latch strobe for edge detect
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ale_d_r <= 1'b0;
      end else begin
         ale_d_r <= ale_s;
      end
   end

   // (RULE_03) address latched on strobe fall
   always_ff @(posedge clk_sys) begin
      if (srst || iface_rst) begin
         addr_r <= EPP_ADDR_RESET;
      end else if (ale_d_r && !ale_s) begin
         addr_r <= bus_s;
      end
   end
   assign prog_addr_out = addr_r;

   // access phase machine: one pulse per strobe assertion
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         EPP_IDLE: begin
            if (rd_req) begin
               state_nxt = EPP_READ;
            end else if (wr_req) begin
               state_nxt = EPP_WRITE;
            end
         end
         EPP_READ: begin
            if (!rd_req) begin
               state_nxt = EPP_IDLE;
            end
         end
         EPP_WRITE: begin
            if (!wr_req) begin
               state_nxt = EPP_IDLE;
            end
         end
         default: state_nxt = EPP_IDLE;
      endcase
   end

   // phase register
   always_ff @(posedge clk_sys) begin
      if (srst || iface_rst) begin
         state_r <= EPP_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // access pulses to the array controller, one cycle at strobe start
   assign prog_wr_pulse = (state_r == EPP_IDLE) && wr_req && !iface_rst;
   assign prog_rd_pulse = (state_r == EPP_IDLE) && rd_req && !iface_rst;

   // (RULE_06) write stores bus byte
   always_ff @(posedge clk_sys) begin
      if (srst || iface_rst) begin
         for (int i = 0; i < N_REGS; i++) begin
            regs_r[i] <= EPP_REG_RESET;
         end
      end else if (prog_wr_pulse && addr_hits_reg(addr_r)) begin
         regs_r[addr_r[EPP_ADDR_W-1:0]] <= bus_s;
      end
   end

   // (RULE_02) read data from registers or array
   always_ff @(posedge clk_sys) begin
      if (srst || iface_rst) begin
         rd_data_r <= EPP_REG_RESET;
      end else if (prog_rd_pulse) begin
         rd_data_r <= addr_hits_reg(addr_r) ? regs_r[addr_r[EPP_ADDR_W-1:0]]
                                            : array_rd_data;
      end
   end
   assign prog_addr_data_bus_o = rd_data_r;

   // (RULE_05) drivers on during read phase only
   assign prog_addr_data_bus_oe = (state_r == EPP_READ) && rd_req;

   // (RULE_03) address follows strobe fall
   a_addr_latch: assert property (@(posedge clk_sys) disable iff (srst || iface_rst) // RULE_03
      ($fell(ale_s)) |=> (addr_r == $past(bus_s)))
      else $error("address not latched on strobe fall");

   // (RULE_05) drive needs select and read
   a_drive_gate: assert property (@(posedge clk_sys) disable iff (srst) // RULE_05
      prog_addr_data_bus_oe |-> (!cs_n_s && !rd_n_s))
      else $error("bus driven without select and read");

   sequence s_rd_start;
      (state_r == EPP_IDLE) && rd_req ##1 rd_req;
   endsequence

   // (RULE_05) read enables drivers next cycle
   a_read_drive: assert property (@(posedge clk_sys) disable iff (srst || iface_rst) // RULE_05
      s_rd_start |-> prog_addr_data_bus_oe)
      else $error("read did not enable drivers");

   // (RULE_06) write lands in register
   a_write_store: assert property (@(posedge clk_sys) disable iff (srst || iface_rst) // RULE_06
      (prog_wr_pulse && addr_hits_reg(addr_r)) |=>
         (regs_r[$past(addr_r[EPP_ADDR_W-1:0])] == $past(bus_s)))
      else $error("write byte not stored");

   // (RULE_07) no access while deselected
   a_select_gate: assert property (@(posedge clk_sys) disable iff (srst) // RULE_07
      cs_n_s |-> (!prog_wr_pulse && !prog_rd_pulse && !prog_addr_data_bus_oe))
      else $error("access while deselected");

   // (RULE_01) reset clears address and phase
   a_iface_reset: assert property (@(posedge clk_sys) disable iff (srst) // RULE_01
      prog_iface_reset_s |=> (addr_r == EPP_ADDR_RESET && state_r == EPP_IDLE && rd_data_r == EPP_REG_RESET))
      else $error("interface reset not applied");

   // (RULE_10) mode tracks pin pattern
   a_mode_entry: assert property (@(posedge clk_sys) disable iff (srst) // RULE_10
      (mode_s != EPP_MODE_PATTERN) |=> !prog_mode_active)
      else $error("mode active with wrong pattern");

   // (RULE_02) read data comes from the array outside register space
   a_array_read: assert property (@(posedge clk_sys) disable iff (srst || iface_rst) // RULE_02
      (prog_rd_pulse && !addr_hits_reg(addr_r)) |=> (rd_data_r == $past(array_rd_data)))
      else $error("array data not returned");
endmodule

// [rtl/epp_sync.sv]
// two flip-flop synchroniser for a group of asynchronous pins
// assumes pins are quasi-static relative to the 40 ns clock
`timescale 1ns/100ps
module epp_sync #(
   parameter int       WIDTH = 1,
   parameter logic     RST_VAL = 1'b0
) (
   input  wire logic             clk_sys,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] meta_r;   // first stage, read only by second stage

   // two stages; both reset to RST_VAL, which need not be the idle level of the pins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta_r   <= {WIDTH{RST_VAL}};
         pin_sync <= {WIDTH{RST_VAL}};
      end else begin
         meta_r   <= pin_in;
         pin_sync <= meta_r;
      end
   end
endmodule

// [tb/epp_port_test.sv]
// self-checking bench for the eeprom programming port
// assumes the programmer model in epp_prog_model.sv
`timescale 1ns/100ps
module epp_port_test;
   import epp_pkg::*;
   logic       clk_sys;   // system clock
   logic       srst;      // sync reset
   logic       ifc_rst;   // interface reset pin
   logic [3:0] mode;      // mode pins, sel3..sel0
   logic [7:0] arr;       // array read data
   logic [7:0] bo, bi, q; // bus out, resolved bus, read value
   logic       oe, act;   // bus enable, mode detected
   int         oe_cnt;    // cycles with the bus driven
   logic       wp, rp;    // write and read access pulses
   logic [7:0] ao;        // latched address output
   int         wp_cnt;    // write pulses seen
   int         rp_cnt;    // read pulses seen
   wire        m_ale, m_cs, m_rd, m_wr; // programmer strobes
   int         error_cnt;
   int         checks;
   epp_port epp_port_i (.clk_sys(clk_sys), .srst(srst), .prog_iface_reset(ifc_rst),
      .prog_mode_sel_0(mode[0]), .prog_mode_sel_1(mode[1]), .prog_mode_sel_2(mode[2]),
      .prog_mode_sel_3(mode[3]), .prog_addr_latch_strobe(m_ale), .prog_select_n(m_cs),
      .prog_read_strobe_n(m_rd), .prog_write_strobe_n(m_wr), .prog_addr_data_bus_i(bi),
      .prog_addr_data_bus_o(bo), .prog_addr_data_bus_oe(oe), .prog_mode_active(act),
      .prog_addr_out(ao), .prog_wr_pulse(wp), .prog_rd_pulse(rp), .array_rd_data(arr));
   epp_prog_model epp_prog_model_i (.clk_sys(clk_sys), .prog_addr_latch_strobe(m_ale),
      .prog_select_n(m_cs), .prog_read_strobe_n(m_rd), .prog_write_strobe_n(m_wr),
      .bus_in(bi), .bus_out(bo), .bus_oe(oe));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // counts driven cycles so deselected accesses can be judged
   always @(posedge clk_sys) oe_cnt <= oe_cnt + int'(oe);
   // counts access pulses so one strobe gives exactly one access
   always @(posedge clk_sys) begin
      wp_cnt <= wp_cnt + int'(wp);
      rp_cnt <= rp_cnt + int'(rp);
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      epp_prog_model_i.access(a, 1'b0, 1'b0, 8'h00, v);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      epp_prog_model_i.access(a, 1'b1, 1'b0, d, q);
   endtask
   task automatic t_reset_vals;
      for (int i = 0; i < EPP_NUM_REGS; i++) begin
         rd(8'(i), q);
         check(q, EPP_REG_RESET, "reset value");
      end
      $display("done reset values");
   endtask
   task automatic t_write_read;
      int w0, r0;
      w0 = wp_cnt;
      for (int i = 0; i < EPP_NUM_REGS; i++) wr(8'(i), 8'hC3 + 8'(i));
      check(8'(wp_cnt - w0), 8'(EPP_NUM_REGS), "write pulse count");
      r0 = rp_cnt;
      for (int i = 0; i < EPP_NUM_REGS; i++) begin
         rd(8'(i), q);
         check(q, 8'hC3 + 8'(i), "readback");
      end
      check(8'(rp_cnt - r0), 8'(EPP_NUM_REGS), "read pulse count");
      $display("done write read");
   endtask
   task automatic t_array;
      arr = 8'h96;
      rd(8'h80, q);
      check(q, 8'h96, "array high");
      arr = 8'h69;
      rd(8'h10, q);
      check(q, 8'h69, "array above regs");
      check(ao, 8'h10, "latched address");
      $display("done array");
   endtask
   task automatic t_deselected;
      int n0, p0;
      n0 = oe_cnt;
      p0 = wp_cnt + rp_cnt;
      epp_prog_model_i.access(8'h03, 1'b1, 1'b1, 8'h11, q);
      epp_prog_model_i.access(8'h03, 1'b0, 1'b1, 8'h00, q);
      check(8'(oe_cnt - n0), 8'h00, "bus driven unselected");
      check(8'(wp_cnt + rp_cnt - p0), 8'h00, "pulse unselected");
      rd(8'h03, q);
      check(q, 8'hC6, "unselected write");
      $display("done deselected");
   endtask
   task automatic t_iface_reset;
      ifc_rst = 1'b1;
      step(6);
      ifc_rst = 1'b0;
      step(6);
      rd(8'h03, q);
      check(q, EPP_REG_RESET, "iface reset");
      $display("done iface reset");
   endtask
   task automatic t_mode;
      wr(8'h05, 8'h5A);
      rd(8'h05, q);
      check(q, 8'h5A, "stored before exit");
      mode = EPP_MODE_PATTERN ^ 4'h1;
      step(6);
      check(8'(act), 8'h00, "wrong pattern");
      mode = EPP_MODE_PATTERN;
      step(6);
      check(8'(act), 8'h01, "pattern back");
      rd(8'h05, q);
      check(q, EPP_REG_RESET, "mode exit clears");
      $display("done mode");
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      {srst, ifc_rst, mode, arr, oe_cnt, error_cnt, checks} = {2'b10, 4'h0, 8'h00, 96'd0};
      {wp_cnt, rp_cnt} = 64'd0;
      step(6);
      srst = 1'b0;
      mode = EPP_MODE_PATTERN;
      step(6);
      check(8'(act), 8'h01, "mode entry");
      t_reset_vals();
      t_write_read();
      t_array();
      t_deselected();
      t_iface_reset();
      t_mode();
      summarize();
   end
   // about 1500 edges of traffic; over thirteen times that means a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      summarize();
   end
endmodule

// [tb/epp_prog_model.sv]
// programmer model for the eeprom programming port: strobes and shared bus
// assumes a free-running clk_sys; pins move 1 ns after a rising edge
`timescale 1ns/100ps
module epp_prog_model
   import epp_pkg::*;
(
   input  wire logic                  clk_sys,
   output logic                       prog_addr_latch_strobe,
   output logic                       prog_select_n,
   output logic                       prog_read_strobe_n,
   output logic                       prog_write_strobe_n,
   output logic      [EPP_DATA_W-1:0] bus_in,
   input  wire logic [EPP_DATA_W-1:0] bus_out,
   input  wire logic                  bus_oe
);
   logic                  drv_r;  // programmer drives the bus
   logic [EPP_DATA_W-1:0] val_r;  // level the programmer drives
   logic [EPP_DATA_W-1:0] last_r; // last resolved level
   // no pull-up: a floating bus flips every cycle so stale data never passes
   assign bus_in = (bus_oe === 1'b1) ? bus_out : (drv_r ? val_r : ~last_r);
   always @(posedge clk_sys) last_r <= bus_in;
   initial begin
      {drv_r, val_r, last_r} = '0;
      prog_addr_latch_strobe = 1'b0;
      {prog_select_n, prog_read_strobe_n, prog_write_strobe_n} = 3'b111;
   end
   // wait n edges, then step off the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // latch pulse first, one strobe, deselect after
   task automatic access(input logic [7:0] a, input logic wr, input logic cs_n,
                         input logic [7:0] d, output logic [7:0] q);
      drv_r = 1'b1;
      val_r = a;
      prog_addr_latch_strobe = 1'b1;
      step(4);
      prog_addr_latch_strobe = 1'b0;
      step(4);
      drv_r = wr;
      val_r = d;
      prog_select_n = cs_n;
      prog_read_strobe_n = wr;
      prog_write_strobe_n = !wr;
      // read data stands while the strobe is low; 10 edges covers its latency
      step(10);
      q = bus_in;
      {prog_read_strobe_n, prog_write_strobe_n} = 2'b11;
      step(4);
      prog_select_n = 1'b1;
      drv_r = 1'b0;
      step(4);
   endtask
endmodule
